// File: core/lulc_pkg.sv
package lulc_pkg;

  // ==========================================================
  // register byte offsets (apb, one aligned word each)
  localparam logic [7:0] LULC_OFS_CTRL2  = 8'h00;  // line_channel_control_two
  localparam logic [7:0] LULC_OFS_CTRL3  = 8'h04;  // line_channel_control_three
  localparam logic [7:0] LULC_OFS_STAT   = 8'h08;  // sticky status, read only
  localparam logic [7:0] LULC_OFS_IEN    = 8'h0C;  // interrupt enable
  localparam logic [7:0] LULC_OFS_ICLR   = 8'h10;  // write-one-to-clear
  localparam logic [7:0] LULC_OFS_LSTAT  = 8'h14;  // live loop state

  // ==========================================================
  // field positions
  localparam int LULC_BIT_TXON    = 3;  // control two, driver on
  localparam int LULC_LSB_LOOP    = 0;  // control two, loopback_select
  localparam int LULC_LSB_DETSEL  = 6;  // control three, detect select
  localparam int LULC_BIT_CODE    = 5;  // control three, line code
  localparam int LULC_BIT_FLAG    = 3;  // status/enable, detected flag

  // reset values
  localparam logic [7:0] LULC_RST_CTRL2 = 8'h00;
  localparam logic [7:0] LULC_RST_CTRL3 = 8'h00;

  // ==========================================================
  // timing: 5 s qualification at 25 MHz
  localparam longint LULC_QUAL_MS     = 5000;
  localparam longint LULC_CLK_HZ      = 25000000;
  localparam longint LULC_QUAL_CYCLES = LULC_QUAL_MS * LULC_CLK_HZ / 1000;

  // ==========================================================
  // enumerations
  typedef enum logic [2:0] {
    LULC_LB_NONE    = 3'b000,
    LULC_LB_DUAL    = 3'b100,
    LULC_LB_ANALOG  = 3'b101,
    LULC_LB_REMOTE  = 3'b110,
    LULC_LB_DIGITAL = 3'b111
  } lulc_loop_t;

  typedef enum logic [1:0] {
    LULC_DET_OFF  = 2'b00,
    LULC_DET_UP   = 2'b01,
    LULC_DET_DOWN = 2'b10,
    LULC_DET_AUTO = 2'b11
  } lulc_det_t;

  // automatic mode states, gray along idle, watch up, looped
  typedef enum logic [1:0] {
    LULC_AS_IDLE   = 2'b00,
    LULC_AS_WATCH  = 2'b01,
    LULC_AS_LOOPED = 2'b11
  } lulc_auto_t;

  // line outputs with enables
  typedef struct packed {
    logic pos;
    logic neg;
    logic posOe;
    logic negOe;
  } lulc_line_t;

  // decoded loop mode outputs
  typedef struct packed {
    logic dual;
    logic analog;
    logic remote;
    logic digital;
  } lulc_loopsel_t;

endpackage

// File: core/lulc_line_ctrl.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module lulc_line_ctrl
  import lulc_pkg::*;
#(
  parameter longint QUAL_CYCLES = LULC_QUAL_CYCLES  // shorten in simulation
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // line side
  input  wire logic        rxData,        // single-rail receive data, async pin
  input  wire logic        txPos,         // encoded transmit rails from coder
  input  wire logic        txNeg,
  output lulc_line_t       txLine,        // tx_line_positive / negative with enables
  output lulc_loopsel_t    loopMode,      // effective loop-back mode
  output logic             useAmi,        // line code choice for coder/decoder
  output logic             irq
);

  // ==========================================================
  // registers
  logic [7:0]    ctrl2;        // driver on, loopback_select
  logic [7:0]    ctrl3;        // detect select, line code, spare
  logic [7:0]    stat;         // sticky events
  logic [7:0]    ien;          // interrupt enables
  logic [31:0]   qualCnt;      // persistence counter
  logic [2:0]    phase;        // position inside the repeating pattern
  logic          rxS1, rxS2;   // synchroniser
  lulc_auto_t    autoState;
  lulc_det_t     detSel, detSelQ;
  logic          wrEn, rdEn, detEvent, wantUp, watching;
  logic [2:0]    period;
  logic          expBit, qualDone;

  // ==========================================================
  // apb: zero-wait slave, unmapped reads zero with error
  assign pready = 1'b1;
  assign wrEn   = psel && penable && pwrite;
  assign rdEn   = psel && !penable && !pwrite;

  logic mapped;
  always_comb begin
    case (paddr)
      LULC_OFS_CTRL2, LULC_OFS_CTRL3, LULC_OFS_STAT,
      LULC_OFS_IEN, LULC_OFS_ICLR, LULC_OFS_LSTAT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;

  // read data captured in setup so it is a flop at the access edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= 32'h0000_0000;
    end else if (rdEn) begin
      case (paddr)
        LULC_OFS_CTRL2: prdata <= {24'h00_0000, ctrl2};
        LULC_OFS_CTRL3: prdata <= {24'h00_0000, ctrl3};
        LULC_OFS_STAT:  prdata <= {24'h00_0000, stat};
        LULC_OFS_IEN:   prdata <= {24'h00_0000, ien};
        LULC_OFS_LSTAT: prdata <= {30'h0000_0000, autoState};
        default:        prdata <= 32'h0000_0000;  // clear reg reads zero
      endcase
    end
  end

  // control writes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl2 <= LULC_RST_CTRL2;
      ctrl3 <= LULC_RST_CTRL3;
      ien   <= 8'h00;
    end else if (wrEn) begin
      if (paddr == LULC_OFS_CTRL2) ctrl2 <= {4'h0, pwdata[3:0]};
      if (paddr == LULC_OFS_CTRL3) ctrl3 <= pwdata[7:0];
      if (paddr == LULC_OFS_IEN)   ien[LULC_BIT_FLAG] <= pwdata[LULC_BIT_FLAG];
    end
  end

  assign detSel = lulc_det_t'(ctrl3[LULC_LSB_DETSEL +: 2]);
  assign useAmi = ctrl3[LULC_BIT_CODE];

  // ==========================================================
  // receive synchroniser; first flop feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxS1 <= 1'b0;
      rxS2 <= 1'b0;
    end else begin
      rxS1 <= rxData;
      rxS2 <= rxS1;
    end
  end

  // which code is being watched; assumed: rxData is single rail
  always_comb begin
    case (detSel)
      LULC_DET_UP:   wantUp = 1'b1;
      LULC_DET_DOWN: wantUp = 1'b0;
      LULC_DET_AUTO: wantUp = (autoState != LULC_AS_LOOPED);
      default:       wantUp = 1'b1;
    endcase
  end
  assign watching = (detSel != LULC_DET_OFF);
  assign period   = wantUp ? 3'd5 : 3'd3;
  // expected bit: one at last position of period, zeros before
  assign expBit   = (phase == period - 3'd1);

  // ==========================================================
  // pattern tracker: phase locks on a one, any mismatch restarts
  // trade-off: locking on the one needs no search over alignments
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase    <= 3'd0;
      qualCnt  <= 32'h0000_0000;
    end else begin
      if (!watching || detSel != detSelQ || qualDone) begin
        phase   <= 3'd0;
        qualCnt <= 32'h0000_0000;
      end else if (rxS2 != expBit) begin
        // break in continuity restarts the count
        phase   <= rxS2 ? 3'd0 : 3'd1;
        qualCnt <= 32'h0000_0000;
      end else begin
        phase   <= expBit ? 3'd0 : phase + 3'd1;
        qualCnt <= qualCnt + 32'h0000_0001;
      end
    end
  end

  // count reaching exactly 5 s marks qualification
  assign qualDone = watching && (qualCnt == 32'(QUAL_CYCLES));
  assign detEvent = qualDone;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      detSelQ <= LULC_DET_OFF;
    end else begin
      detSelQ <= detSel;
    end
  end

  // ==========================================================
  // automatic remote loop-back machine
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      autoState <= LULC_AS_IDLE;
    end else if (detSel != LULC_DET_AUTO) begin
      autoState <= LULC_AS_IDLE;
    end else begin
      case (autoState)
        LULC_AS_IDLE:   autoState <= LULC_AS_WATCH;
        LULC_AS_WATCH:  if (qualDone) autoState <= LULC_AS_LOOPED;
        LULC_AS_LOOPED: if (qualDone) autoState <= LULC_AS_WATCH;
        default:        autoState <= LULC_AS_IDLE;
      endcase
    end
  end

  // ==========================================================
  // sticky status: set wins over clear; auto entry clears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stat <= 8'h00;
    end else if (detEvent && !(detSel == LULC_DET_AUTO && autoState == LULC_AS_LOOPED)) begin
      stat[LULC_BIT_FLAG] <= 1'b1;
    end else if (detSel == LULC_DET_AUTO && detSelQ != LULC_DET_AUTO) begin
      stat[LULC_BIT_FLAG] <= 1'b0;
    end else if (wrEn && paddr == LULC_OFS_ICLR && pwdata[LULC_BIT_FLAG]) begin
      stat[LULC_BIT_FLAG] <= 1'b0;
    end
  end

  assign irq = |(stat & ien);

  // ==========================================================
  // loop mode decode; auto loop forces remote
  always_comb begin
    loopMode = '0;
    if (autoState == LULC_AS_LOOPED) begin
      loopMode.remote = 1'b1;
    end else begin
      case (lulc_loop_t'(ctrl2[LULC_LSB_LOOP +: 3]))
        LULC_LB_DUAL:    loopMode.dual    = 1'b1;
        LULC_LB_ANALOG:  loopMode.analog  = 1'b1;
        LULC_LB_REMOTE:  loopMode.remote  = 1'b1;
        LULC_LB_DIGITAL: loopMode.digital = 1'b1;
        default:         loopMode         = '0;    // msb zero: none
      endcase
    end
  end

  // ==========================================================
  // transmit driver; off means both enables low
  always_comb begin
    txLine.pos   = txPos;
    txLine.neg   = txNeg;
    txLine.posOe = ctrl2[LULC_BIT_TXON];
    txLine.negOe = ctrl2[LULC_BIT_TXON];
  end

  // ==========================================================
  // assertions
  // auto entry; the quiet form leaves out a detection in the same
  // cycle, because a landing detection wins over the entry clear
  sequence s_enter_auto;
    detSel == LULC_DET_AUTO && detSelQ != LULC_DET_AUTO;
  endsequence
  sequence s_enter_quiet;
    detSel == LULC_DET_AUTO && detSelQ != LULC_DET_AUTO && !detEvent;
  endsequence
  // qualification landing while auto watches loop-up or loop-down
  sequence s_up_qualified;
    detSel == LULC_DET_AUTO && autoState == LULC_AS_WATCH && qualDone;
  endsequence
  sequence s_down_qualified;
    detSel == LULC_DET_AUTO && autoState == LULC_AS_LOOPED && qualDone;
  endsequence

  // register side
  a_driver_off_tristate: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl2[LULC_BIT_TXON] |-> !txLine.posOe && !txLine.negOe)
    else $error("driver enabled while off");
  a_ctrl2_write: assert property (@(posedge clk) disable iff (!rst_b)
    wrEn && paddr == LULC_OFS_CTRL2 |=> txLine.posOe == $past(pwdata[LULC_BIT_TXON]))
    else $error("driver enable not written");
  a_loop_none: assert property (@(posedge clk) disable iff (!rst_b)
    !ctrl2[2] && autoState != LULC_AS_LOOPED |-> loopMode == '0)
    else $error("loop active with msb zero");
  a_line_code: assert property (@(posedge clk) disable iff (!rst_b)
    wrEn && paddr == LULC_OFS_CTRL3 |=> useAmi == $past(pwdata[LULC_BIT_CODE]))
    else $error("line code mismatch");

  // detection and status
  a_off_no_count: assert property (@(posedge clk) disable iff (!rst_b)
    detSel == LULC_DET_OFF |=> qualCnt == 32'h0000_0000)
    else $error("counting while disabled");
  a_qual_span: assert property (@(posedge clk) disable iff (!rst_b)
    qualDone |-> $past(qualCnt) == 32'(QUAL_CYCLES - 1))
    else $error("qualified without full count");
  a_break_restart: assert property (@(posedge clk) disable iff (!rst_b)
    watching && detSel == detSelQ && !qualDone && rxS2 != expBit
    |=> qualCnt == 32'h0000_0000)
    else $error("count not restarted");
  a_flag_set: assert property (@(posedge clk) disable iff (!rst_b)
    detEvent && autoState != LULC_AS_LOOPED |=> stat[LULC_BIT_FLAG])
    else $error("flag not set on detection");
  a_flag_sticky: assert property (@(posedge clk) disable iff (!rst_b)
    stat[LULC_BIT_FLAG] && !(wrEn && paddr == LULC_OFS_ICLR)
    && !(detSel == LULC_DET_AUTO && detSelQ != LULC_DET_AUTO) |=> stat[LULC_BIT_FLAG])
    else $error("flag lost without clear");
  a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
    irq == (stat[LULC_BIT_FLAG] && ien[LULC_BIT_FLAG]))
    else $error("interrupt mismatch");

  // automatic loop-back
  a_auto_clears: assert property (@(posedge clk) disable iff (!rst_b)
    s_enter_quiet |=> !stat[LULC_BIT_FLAG])
    else $error("flag not cleared on auto entry");
  a_auto_watch: assert property (@(posedge clk) disable iff (!rst_b)
    s_enter_auto |=> autoState == LULC_AS_WATCH)
    else $error("auto entry not watching loop-up");
  a_auto_activate: assert property (@(posedge clk) disable iff (!rst_b)
    s_up_qualified |=> loopMode.remote)
    else $error("remote not activated");
  a_auto_holds: assert property (@(posedge clk) disable iff (!rst_b)
    autoState == LULC_AS_LOOPED && !qualDone && detSel == LULC_DET_AUTO
    |=> autoState == LULC_AS_LOOPED)
    else $error("auto loop dropped early");
  a_watch_down: assert property (@(posedge clk) disable iff (!rst_b)
    autoState == LULC_AS_LOOPED && detSel == LULC_DET_AUTO |-> !wantUp)
    else $error("not watching loop-down");
  a_release_down: assert property (@(posedge clk) disable iff (!rst_b)
    s_down_qualified |=> autoState == LULC_AS_WATCH)
    else $error("auto loop not released by loop-down");
  a_release_off: assert property (@(posedge clk) disable iff (!rst_b)
    $fell(detSel == LULC_DET_AUTO) |-> ##1 autoState == LULC_AS_IDLE)
    else $error("auto loop not released");

endmodule

`default_nettype wire

// File: verification/lulc_remote_model.sv
`timescale 1ns/1ps
`default_nettype none

// remote line terminal: sends loop codes as single-rail bits
module lulc_remote_model
  import lulc_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire lulc_det_t sendCode,  // up, down, or all ones otherwise
  output logic           rxData
);
  logic [2:0] phase;  // position inside the repeating code

  // ==========================================================
  // code generator, one bit per clock, single-rail only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase  <= 3'h0;
      rxData <= 1'b1;
    end else if (sendCode == LULC_DET_UP) begin  // four zeros then a one
      rxData <= (phase == 3'h4);
      phase  <= (phase == 3'h4) ? 3'h0 : phase + 3'h1;
    end else if (sendCode == LULC_DET_DOWN) begin  // two zeros then a one
      rxData <= (phase == 3'h2);
      phase  <= (phase >= 3'h2) ? 3'h0 : phase + 3'h1;
    end else begin
      // all ones breaks both codes
      rxData <= 1'b1;
      phase  <= 3'h0;
    end
  end
endmodule

`default_nettype wire

// File: verification/line_unit_loopback_loop_code_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module line_unit_loopback_loop_code_ctrl_tb
  import lulc_pkg::*;
;
  // ==========================================================
  // signals
  logic          clk, rst_b, psel, penable, pwrite, txPos, txNeg, rxData;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdq;
  logic          pready, pslverr, rde, useAmi, irq;
  lulc_line_t    txLine;
  lulc_loopsel_t loopMode;
  lulc_det_t     sendCode;  // what the remote end transmits
  int            numErrors, checksDone, cycles;

  // short count keeps the run brief
  lulc_line_ctrl #(.QUAL_CYCLES(40)) dut_u (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxData(rxData), .txPos(txPos), .txNeg(txNeg),
    .txLine(txLine), .loopMode(loopMode), .useAmi(useAmi), .irq(irq));

  lulc_remote_model far_u (.clk(clk), .rst_b(rst_b), .sendCode(sendCode), .rxData(rxData));

  // ==========================================================
  // clock, reset, hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin  // far beyond the expected several hundred
      numErrors++;
      tallyAndFinish();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      numErrors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // settle past the edge so flop updates have landed
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed; only the bench timeout ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdq = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdq, exp);
  endtask

  // poll an output bit under a bound
  task automatic waitRemote(input logic lvl);
    for (int n = 0; n < 200 && loopMode.remote !== lvl; n++) cyc(1);
  endtask

  // ==========================================================
  // scenarios
  task automatic tRegs();
    int i;
    rd(LULC_OFS_CTRL2, 32'h0000_0000);
    rd(LULC_OFS_CTRL3, 32'h0000_0000);
    chk(32'(loopMode), 32'h0000_0000);
    apb(1'b1, LULC_OFS_STAT, 32'h0000_0008);
    rd(LULC_OFS_STAT, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    chk(32'(rde), 32'h0000_0001);
    // all eight loop codes, upper bit selects a mode
    for (i = 0; i < 8; i++) begin
      apb(1'b1, LULC_OFS_CTRL2, 32'(i));
      chk(32'(loopMode), i[2] ? 32'h0000_0008 >> i[1:0] : 32'h0000_0000);
    end
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_0020);
    chk(32'(useAmi), 32'h0000_0001);
    rd(LULC_OFS_CTRL3, 32'h0000_0020);
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_0000);
    chk(32'(useAmi), 32'h0000_0000);
  endtask

  task automatic tDriver();
    apb(1'b1, LULC_OFS_CTRL2, 32'h0000_0008);
    chk(32'(txLine), 32'h0000_000B);
    @(posedge clk);
    txPos <= 1'b0;
    txNeg <= 1'b1;
    cyc(1);
    chk(32'(txLine), 32'h0000_0007);
    apb(1'b1, LULC_OFS_CTRL2, 32'h0000_0000);
    chk(32'(txLine[1:0]), 32'h0000_0000);
  endtask

  task automatic tManual();
    apb(1'b1, LULC_OFS_IEN, 32'h0000_0008);
    sendCode <= LULC_DET_UP;
    // detection off: a long loop-up code must not raise the flag
    cyc(60);
    rd(LULC_OFS_STAT, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_0040);
    cyc(20);
    chk(32'(irq), 32'h0000_0000);
    // a short break must restart the persistence count
    sendCode <= LULC_DET_OFF;
    cyc(4);
    sendCode <= LULC_DET_UP;
    cyc(30);
    chk(32'(irq), 32'h0000_0000);
    for (int n = 0; n < 200 && irq !== 1'b1; n++) cyc(1);
    chk(32'(irq), 32'h0000_0001);
    rd(LULC_OFS_STAT, 32'h0000_0008);
    apb(1'b1, LULC_OFS_IEN, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // loop-down watch must ignore the loop-up code
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_0080);
    apb(1'b1, LULC_OFS_ICLR, 32'h0000_0008);
    apb(1'b1, LULC_OFS_IEN, 32'h0000_0008);
    cyc(100);
    rd(LULC_OFS_STAT, 32'h0000_0000);
    sendCode <= LULC_DET_DOWN;
    for (int n = 0; n < 200 && irq !== 1'b1; n++) cyc(1);
    chk(32'(irq), 32'h0000_0001);
    sendCode <= LULC_DET_OFF;
  endtask

  task automatic tAuto();
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_00C0);
    rd(LULC_OFS_STAT, 32'h0000_0000);
    rd(LULC_OFS_LSTAT, 32'h0000_0001);
    sendCode <= LULC_DET_UP;
    waitRemote(1'b1);
    chk(32'(loopMode), 32'h0000_0002);
    rd(LULC_OFS_STAT, 32'h0000_0008);
    rd(LULC_OFS_LSTAT, 32'h0000_0003);
    sendCode <= LULC_DET_OFF;
    cyc(100);
    chk(32'(loopMode), 32'h0000_0002);
    sendCode <= LULC_DET_UP;
    cyc(100);
    chk(32'(loopMode), 32'h0000_0002);
    sendCode <= LULC_DET_DOWN;
    waitRemote(1'b0);
    chk(32'(loopMode), 32'h0000_0000);
    sendCode <= LULC_DET_UP;
    waitRemote(1'b1);
    chk(32'(loopMode), 32'h0000_0002);
    apb(1'b1, LULC_OFS_CTRL3, 32'h0000_0000);
    cyc(2);
    chk(32'(loopMode), 32'h0000_0000);
  endtask

  // ==========================================================
  // closing report, the only exit
  task automatic tallyAndFinish();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {numErrors, checksDone, cycles} = '0;
    rst_b = 1'b0;
    txPos = 1'b1;
    txNeg = 1'b0;
    sendCode = LULC_DET_OFF;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    tRegs();
    tDriver();
    tManual();
    tAuto();
    tallyAndFinish();
  end
endmodule

`default_nettype wire
